// [design/bridge_txn_pkg.sv]
// shared encodings and constants for the bridge transaction core
package bridge_txn_pkg;

  // pci bus command codes
  localparam logic [3:0] PCI_INT_ACK   = 4'h0;
  localparam logic [3:0] PCI_SPECIAL   = 4'h1;
  localparam logic [3:0] PCI_IO_RD     = 4'h2;
  localparam logic [3:0] PCI_IO_WR     = 4'h3;
  localparam logic [3:0] PCI_MEM_RD    = 4'h6;
  localparam logic [3:0] PCI_MEM_WR    = 4'h7;
  localparam logic [3:0] PCI_CFG_RD    = 4'ha;
  localparam logic [3:0] PCI_CFG_WR    = 4'hb;
  localparam logic [3:0] PCI_MEM_RD_MUL = 4'hc;
  localparam logic [3:0] PCI_DUAL_ADDR = 4'hd;
  localparam logic [3:0] PCI_MEM_RD_LN = 4'he;
  localparam logic [3:0] PCI_MEM_WR_INV = 4'hf;

  // tlp kinds, coded locally
  typedef enum logic [3:0] {
    TLP_MRD    = 4'h0,
    TLP_MRDLK  = 4'h1,
    TLP_MWR    = 4'h2,
    TLP_IORD   = 4'h3,
    TLP_IOWR   = 4'h4,
    TLP_CFGRD0 = 4'h5,
    TLP_CFGWR0 = 4'h6,
    TLP_CFGRD1 = 4'h7,
    TLP_CFGWR1 = 4'h8,
    TLP_MSG    = 4'h9,
    TLP_MSGD   = 4'ha,
    TLP_CPL    = 4'hb,
    TLP_CPLD   = 4'hc,
    TLP_CPLLK  = 4'hd,
    TLP_CPLDLK = 4'he,
    TLP_NONE   = 4'hf
  } tlp_kind_e;

  // pcie message codes
  localparam logic [7:0] MSG_UNLOCK     = 8'h00;
  localparam logic [7:0] MSG_PME        = 8'h18;
  localparam logic [7:0] MSG_ASSERT_INT = 8'h20;
  localparam logic [7:0] MSG_DEASRT_INT = 8'h24;
  localparam logic [5:0] MSG_INTX_HI    = 6'h08;
  localparam logic [5:0] MSG_ERR_HI     = 6'h0c;
  localparam logic [3:0] MSG_IGNORE_HI  = 4'h4;
  localparam logic [7:0] MSG_SLOT_PWR   = 8'h50;
  localparam logic [7:0] MSG_VENDOR_T0  = 8'h7e;
  localparam logic [7:0] MSG_VENDOR_T1  = 8'h7f;

  // slot power payload layout
  localparam int SLOT_VAL_LSB   = 0;
  localparam int SLOT_VAL_W     = 8;
  localparam int SLOT_SCALE_LSB = 8;
  localparam int SLOT_SCALE_W   = 2;

  // what happens to a received tlp
  typedef enum logic [2:0] {
    RX_ACCEPT    = 3'h0,
    RX_UR        = 3'h1,
    RX_MALFORMED = 3'h2,
    RX_DROP      = 3'h3,
    RX_IGNORE    = 3'h4,
    RX_CONSUME   = 3'h5
  } rx_disp_e;

  // answer to a pci target access
  typedef enum logic [1:0] {
    TGT_NONE   = 2'h0,
    TGT_CLAIM  = 2'h1,
    TGT_RETRY  = 2'h2,
    TGT_MABORT = 2'h3
  } tgt_resp_e;

  typedef enum logic [1:0] {
    LK_IDLE   = 2'b00,
    LK_DRAIN  = 2'b01,
    LK_TARGET = 2'b10,
    LK_FULL   = 2'b11
  } lock_state_e;

  localparam int INT_LINES = 4;

endpackage : bridge_txn_pkg

// [design/bridge_txn_order_lock.sv]
// transaction filter, ordering selector, message generator and lock machine
// What this block does
// - master issues only listed pci commands
// - target claims only io and memory commands
// - pcie receive accepts listed tlps, no vendor msgd
// - pcie transmit never mrdlk, config or msgd
// - legacy interrupt edges become assert/deassert messages
// - power event input becomes pme message
// - slot power message loads scale and value
// - device id messages master-aborted, never forwarded
// - vendor type1 msg dropped, type1 msgd and type0 unsupported request
// - ignored no effect, error ur, intx malformed
// - posted never passes earlier posted
// - read completion passes posted only if relaxed
// - nonposted and non-relaxed completions never pass earlier posted
// - upstream traffic ignores pci lock line
// - lock needs mrdlk, lock line, target trdy
// - target-lock on mrdlk, full on success, unlock msg
// - locked read waits for earlier requests done
// - target-lock answers every received tlp ur except unlock msg, cpl and cpld
// - full-lock retries upstream, non-memory downstream ur
// - locked holds upstream queue and messages, completions pass
// - once locked every downstream cycle drives lock line
// - initial abort no lock plus error completion
`timescale 1ns/1ps
module bridge_txn_order_lock
  import bridge_txn_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  // pcie receive descriptor
  input  wire logic                 rx_valid,
  input  wire tlp_kind_e            rx_kind,
  input  wire logic [7:0]           rx_msg_code,
  input  wire logic [15:0]          rx_payload,
  output logic                      rx_done,
  output rx_disp_e                  rx_disp,
  // pcie transmit request filter
  input  wire logic                 tx_valid,
  input  wire tlp_kind_e            tx_kind,
  output logic                      tx_grant,
  output logic                      tx_refused,
  // pci target side
  input  wire logic                 tgt_valid,
  input  wire logic [3:0]           tgt_cmd,
  input  wire logic                 tgt_devid_msg,
  output logic                      tgt_done,
  output tgt_resp_e                 tgt_resp,
  // pci master side
  input  wire logic                 mst_valid,
  input  wire logic [3:0]           mst_cmd,
  output logic                      mst_go,
  output logic                      mst_refused,
  // ordering selector heads
  input  wire logic                 p_valid,
  input  wire logic                 np_valid,
  input  wire logic                 np_behind_p,
  input  wire logic                 cpl_valid,
  input  wire logic                 cpl_is_read,
  input  wire logic                 cpl_ro,
  input  wire logic                 cpl_behind_p,
  output logic                      p_pop,
  output logic                      np_pop,
  output logic                      cpl_pop,
  // lock sequence
  input  wire logic                 dn_prior_done,
  input  wire logic                 lk_rd_end,
  input  wire logic                 lk_rd_trdy,
  input  wire logic                 lk_rd_abort,
  output logic                      lk_rd_start,
  output logic                      lk_err_cpl,
  output logic                      up_hold,
  output lock_state_e               lock_state,
  input  wire logic                 bus_lock_line_n_i,
  output logic                      bus_lock_line_n_o,
  output logic                      bus_lock_line_oe,
  input  wire logic                 dn_cycle_active,
  // interrupt and power event inputs, active low
  input  wire logic [INT_LINES-1:0] int_line_n,
  input  wire logic                 pm_event_input_n,
  // outgoing message request
  output logic                      msg_valid,
  output logic [7:0]                msg_code,
  input  wire logic                 msg_ready,
  // device capability fields
  output logic [SLOT_SCALE_W-1:0]   slot_pwr_scale,
  output logic [SLOT_VAL_W-1:0]     slot_pwr_value
);

  lock_state_e              lock_r;
  lock_state_e              lock_nxt;
  logic [INT_LINES-1:0]     int_prev_r;
  logic [INT_LINES-1:0]     asrt_pend_r;
  logic [INT_LINES-1:0]     dasrt_pend_r;
  logic                     pme_prev_r;
  logic                     pme_pend_r;
  logic [1:0]               rr_r;
  logic                     rd_issued_r;
  logic                     is_mem_rx;
  logic                     msg_pick_int;
  logic [1:0]               pick_line;
  logic                     pick_asrt;
  logic                     pick_found;
  rx_disp_e                 disp_c;

  assign lock_state = lock_r;

  ////////////////////////////////////////////////////////////////////////
  // pcie receive classification

  assign is_mem_rx = (rx_kind == TLP_MRD) || (rx_kind == TLP_MWR) ||
                     (rx_kind == TLP_MRDLK);

  always_comb begin
    disp_c = RX_ACCEPT;
    case (rx_kind)
      TLP_CPLLK, TLP_CPLDLK, TLP_NONE: disp_c = RX_MALFORMED;
      TLP_MSG, TLP_MSGD: begin
        if (rx_msg_code == MSG_VENDOR_T1) begin
          disp_c = (rx_kind == TLP_MSGD) ? RX_UR : RX_DROP;
        end else if (rx_msg_code == MSG_VENDOR_T0) begin
          disp_c = RX_UR;
        end else if (rx_msg_code[7:2] == MSG_ERR_HI) begin
          disp_c = RX_UR;
        end else if (rx_msg_code[7:3] == MSG_INTX_HI[5:1]) begin
          disp_c = RX_MALFORMED;
        end else if (rx_msg_code[7:4] == MSG_IGNORE_HI) begin
          disp_c = RX_IGNORE;
        end else if (rx_msg_code == MSG_SLOT_PWR || rx_msg_code == MSG_UNLOCK) begin
          disp_c = RX_CONSUME;
        end else begin
          disp_c = RX_ACCEPT;
        end
      end
      default: disp_c = RX_ACCEPT;
    endcase
    // unlock must always get through, otherwise a lock could never end
    if (!(rx_kind == TLP_MSG && rx_msg_code == MSG_UNLOCK) &&
        !(rx_kind == TLP_CPL || rx_kind == TLP_CPLD)) begin
      if (lock_r == LK_TARGET || lock_r == LK_DRAIN) begin
        disp_c = RX_UR;
      end else if (lock_r == LK_FULL && !is_mem_rx) begin
        disp_c = RX_UR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_done <= 1'b0;
      rx_disp <= RX_ACCEPT;
    end else begin
      rx_done <= rx_valid;
      if (rx_valid) begin
        rx_disp <= disp_c;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      slot_pwr_scale <= '0;
      slot_pwr_value <= '0;
    end else if (rx_valid && disp_c == RX_CONSUME && rx_msg_code == MSG_SLOT_PWR) begin
      slot_pwr_scale <= rx_payload[SLOT_SCALE_LSB +: SLOT_SCALE_W];
      slot_pwr_value <= rx_payload[SLOT_VAL_LSB +: SLOT_VAL_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pcie transmit filter

  always_comb begin
    tx_grant   = 1'b0;
    tx_refused = 1'b0;
    if (tx_valid) begin
      case (tx_kind)
        TLP_MRD, TLP_MWR, TLP_IORD, TLP_IOWR, TLP_MSG: begin
          tx_grant   = !up_hold;
          tx_refused = 1'b0;
        end
        TLP_CPL, TLP_CPLD, TLP_CPLLK, TLP_CPLDLK: tx_grant = 1'b1;
        default: tx_refused = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pci target and master command checks

  always_ff @(posedge clk) begin
    if (srst) begin
      tgt_done <= 1'b0;
      tgt_resp <= TGT_NONE;
    end else begin
      tgt_done <= tgt_valid;
      if (tgt_valid) begin
        // the pci lock line is never looked at here
        if (tgt_devid_msg) begin
          tgt_resp <= TGT_MABORT;
        end else begin
          case (tgt_cmd)
            PCI_IO_RD, PCI_IO_WR, PCI_MEM_RD, PCI_MEM_WR, PCI_MEM_RD_MUL,
            PCI_DUAL_ADDR, PCI_MEM_RD_LN, PCI_MEM_WR_INV:
              tgt_resp <= (lock_r == LK_FULL) ? TGT_RETRY : TGT_CLAIM;
            default: tgt_resp <= TGT_NONE;
          endcase
        end
      end else begin
        tgt_resp <= TGT_NONE;
      end
    end
  end

  always_comb begin
    mst_go      = 1'b0;
    mst_refused = 1'b0;
    if (mst_valid) begin
      case (mst_cmd)
        PCI_SPECIAL, PCI_IO_RD, PCI_IO_WR, PCI_MEM_RD, PCI_MEM_WR, PCI_CFG_RD,
        PCI_CFG_WR, PCI_MEM_RD_MUL, PCI_DUAL_ADDR, PCI_MEM_RD_LN,
        PCI_MEM_WR_INV: mst_go = 1'b1;
        default: mst_refused = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ordering selector: one pop per cycle, posted stream is strictly fifo

  always_comb begin
    p_pop   = 1'b0;
    np_pop  = 1'b0;
    cpl_pop = 1'b0;
    if (cpl_valid && (!cpl_behind_p || !p_valid ||
                      (cpl_is_read && cpl_ro))) begin
      cpl_pop = 1'b1;
    end else if (np_valid && (!np_behind_p || !p_valid)) begin
      np_pop = 1'b1;
    end else if (p_valid) begin
      p_pop = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock machine

  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      LK_IDLE: begin
        if (rx_valid && rx_kind == TLP_MRDLK) begin
          lock_nxt = LK_DRAIN;
        end
      end
      LK_DRAIN: begin
        if (dn_prior_done) begin
          lock_nxt = LK_TARGET;
        end
      end
      LK_TARGET: begin
        if (lk_rd_end && lk_rd_abort) begin
          lock_nxt = LK_IDLE;
        end else if (lk_rd_end && lk_rd_trdy && !bus_lock_line_n_o) begin
          lock_nxt = LK_FULL;
        end
      end
      LK_FULL: begin
        // later aborts leave the lock in place
        if (rx_valid && rx_kind == TLP_MSG && rx_msg_code == MSG_UNLOCK) begin
          lock_nxt = LK_IDLE;
        end
      end
      default: lock_nxt = LK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lock_r <= LK_IDLE;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_issued_r <= 1'b0;
      lk_rd_start <= 1'b0;
      lk_err_cpl  <= 1'b0;
    end else begin
      lk_rd_start <= (lock_r == LK_DRAIN) && dn_prior_done;
      rd_issued_r <= (lock_nxt == LK_TARGET);
      lk_err_cpl  <= (lock_r == LK_TARGET) && lk_rd_end && lk_rd_abort;
    end
  end

  // lock line is driven low during the locked read and during downstream cycles of full lock
  always_comb begin
    bus_lock_line_oe  = 1'b0;
    bus_lock_line_n_o = 1'b1;
    if ((lock_r == LK_TARGET && rd_issued_r) ||
        (lock_r == LK_FULL && dn_cycle_active)) begin
      bus_lock_line_oe  = 1'b1;
      bus_lock_line_n_o = 1'b0;
    end
  end

  assign up_hold = (lock_r == LK_FULL);

  ////////////////////////////////////////////////////////////////////////
  // interrupt and power event messages

  always_ff @(posedge clk) begin
    if (srst) begin
      int_prev_r   <= '1;
      pme_prev_r   <= 1'b1;
      asrt_pend_r  <= '0;
      dasrt_pend_r <= '0;
      pme_pend_r   <= 1'b0;
    end else begin
      int_prev_r <= int_line_n;
      pme_prev_r <= pm_event_input_n;
      for (int i = 0; i < INT_LINES; i++) begin
        // a new edge wins over the clear of the sent flag
        if (msg_valid && msg_ready && msg_pick_int && pick_line == i[1:0]) begin
          if (pick_asrt) begin
            asrt_pend_r[i] <= 1'b0;
          end else begin
            dasrt_pend_r[i] <= 1'b0;
          end
        end
        if (int_prev_r[i] && !int_line_n[i]) begin
          asrt_pend_r[i] <= 1'b1;
        end
        if (!int_prev_r[i] && int_line_n[i]) begin
          dasrt_pend_r[i] <= 1'b1;
        end
      end
      if (msg_valid && msg_ready && !msg_pick_int) begin
        pme_pend_r <= 1'b0;
      end
      if (pme_prev_r && !pm_event_input_n) begin
        pme_pend_r <= 1'b1;
      end
    end
  end

  // round robin over lines; an assert always goes before its deassert
  always_comb begin
    pick_found = 1'b0;
    pick_line  = rr_r;
    pick_asrt  = 1'b0;
    for (int k = 0; k < INT_LINES; k++) begin
      if (!pick_found && (asrt_pend_r[2'(rr_r + k)] || dasrt_pend_r[2'(rr_r + k)])) begin
        pick_found = 1'b1;
        pick_line  = 2'(rr_r + k);
        pick_asrt  = asrt_pend_r[2'(rr_r + k)];
      end
    end
  end

  assign msg_pick_int = pick_found;
  assign msg_valid    = (pick_found || pme_pend_r) && !up_hold;
  assign msg_code     = !pick_found ? MSG_PME :
                        pick_asrt ? (MSG_ASSERT_INT | {6'h00, pick_line}) :
                                    (MSG_DEASRT_INT | {6'h00, pick_line});

  always_ff @(posedge clk) begin
    if (srst) begin
      rr_r <= '0;
    end else if (msg_valid && msg_ready && pick_found) begin
      rr_r <= 2'(pick_line + 2'h1);
    end
  end

endmodule // bridge_txn_order_lock

// [tb/bto_checker_assertions.sv]
// assertion checker for the bridge transaction core
`timescale 1ns/1ps
module bto_checker
  import bridge_txn_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        rx_valid,
  input wire tlp_kind_e   rx_kind,
  input wire logic [7:0]  rx_msg_code,
  input wire rx_disp_e    rx_disp,
  input wire logic        tx_valid,
  input wire tlp_kind_e   tx_kind,
  input wire logic        tx_grant,
  input wire logic        tgt_valid,
  input wire logic [3:0]  tgt_cmd,
  input wire logic        tgt_devid_msg,
  input wire tgt_resp_e   tgt_resp,
  input wire logic        mst_valid,
  input wire logic [3:0]  mst_cmd,
  input wire logic        mst_go,
  input wire logic        p_valid,
  input wire logic        np_valid,
  input wire logic        np_behind_p,
  input wire logic        np_pop,
  input wire logic        cpl_valid,
  input wire logic        cpl_is_read,
  input wire logic        cpl_ro,
  input wire logic        cpl_behind_p,
  input wire logic        cpl_pop,
  input wire logic        dn_prior_done,
  input wire logic        lk_rd_end,
  input wire logic        lk_rd_abort,
  input wire logic        lk_rd_start,
  input wire logic        lk_err_cpl,
  input wire lock_state_e lock_state,
  input wire logic        up_hold,
  input wire logic        msg_valid,
  input wire logic        bus_lock_line_n_o,
  input wire logic        bus_lock_line_oe,
  input wire logic        dn_cycle_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  sequence s_lk_req; rx_valid && rx_kind == TLP_MRDLK && lock_state == LK_IDLE; endsequence
  sequence s_drained; lock_state == LK_DRAIN && dn_prior_done; endsequence
  sequence s_rd_abort; lock_state == LK_TARGET && lk_rd_end && lk_rd_abort; endsequence
  property p_mst_cmd;
    mst_valid && mst_cmd inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9} |-> !mst_go; endproperty
  a_mst_cmd: assert property (p_mst_cmd) else $error("refused master command issued");
  property p_tgt_none; tgt_valid && !tgt_devid_msg &&
    tgt_cmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb} |=> tgt_resp == TGT_NONE;
  endproperty
  a_tgt_none: assert property (p_tgt_none) else $error("target claimed a bad command");
  property p_devid; tgt_valid && tgt_devid_msg |=> tgt_resp == TGT_MABORT; endproperty
  a_devid: assert property (p_devid) else $error("device id message not aborted");
  property p_tx_kind; tx_valid && tx_kind inside {TLP_MRDLK, TLP_CFGRD0, TLP_CFGWR0,
    TLP_CFGRD1, TLP_CFGWR1, TLP_MSGD} |-> !tx_grant; endproperty
  a_tx_kind: assert property (p_tx_kind) else $error("forbidden tlp granted");
  property p_cpl_order; cpl_valid && p_valid && cpl_behind_p && !(cpl_is_read && cpl_ro)
    |-> !cpl_pop; endproperty
  a_cpl_order: assert property (p_cpl_order) else $error("completion passed posted");
  property p_np_order; np_valid && p_valid && np_behind_p |-> !np_pop; endproperty
  a_np_order: assert property (p_np_order) else $error("non-posted passed posted");
  property p_lk_enter; s_lk_req |=> lock_state == LK_DRAIN; endproperty
  a_lk_enter: assert property (p_lk_enter) else $error("locked read not taken");
  property p_lk_issue; s_drained |=> lk_rd_start ##1 !lk_rd_start; endproperty
  a_lk_issue: assert property (p_lk_issue) else $error("locked read not issued once");
  property p_lk_abort; s_rd_abort |=> lock_state == LK_IDLE && lk_err_cpl; endproperty
  a_lk_abort: assert property (p_lk_abort) else $error("abort kept lock");
  property p_lk_ur; rx_valid && lock_state == LK_TARGET &&
    !(rx_kind inside {TLP_CPL, TLP_CPLD, TLP_CPLLK, TLP_CPLDLK, TLP_NONE}) &&
    !(rx_kind == TLP_MSG && rx_msg_code == MSG_UNLOCK) |=> rx_disp == RX_UR; endproperty
  a_lk_ur: assert property (p_lk_ur) else $error("tlp accepted in target lock");
  property p_full_retry; tgt_valid && lock_state == LK_FULL && !tgt_devid_msg &&
    tgt_cmd inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf} |=> tgt_resp == TGT_RETRY;
  endproperty
  a_full_retry: assert property (p_full_retry) else $error("upstream not retried");
  property p_lk_line; lock_state == LK_FULL && dn_cycle_active
    |-> !bus_lock_line_n_o && bus_lock_line_oe; endproperty
  a_lk_line: assert property (p_lk_line) else $error("lock line not driven");
  property p_msg_hold; up_hold |-> !msg_valid; endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("message sent while locked");
endmodule // bto_checker

bind bridge_txn_order_lock bto_checker bto_checker_i (.*);

// [tb/pci_lock_target.sv]
// far-side pci target answering the locked read after a set wait
`timescale 1ns/1ps
module pci_lock_target
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       lk_rd_start,
  input  wire logic       abort_mode,
  input  wire logic [3:0] wait_cyc,
  output logic            lk_rd_end,
  output logic            lk_rd_trdy,
  output logic            lk_rd_abort
);
  logic [3:0] cnt_r;
  logic       busy_r;
  logic       tgl_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cnt_r  <= 4'h0;
    end else if (lk_rd_start) begin
      busy_r <= 1'b1;
      cnt_r  <= wait_cyc;
    end else if (busy_r) begin
      busy_r <= (cnt_r != 4'h0);
      cnt_r  <= cnt_r - 4'h1;
    end
  end
  // qualifiers mean nothing outside the end pulse, so they wander there
  always_ff @(posedge clk) begin
    tgl_r <= srst ? 1'b0 : ~tgl_r;
  end
  assign lk_rd_end   = busy_r && (cnt_r == 4'h0);
  assign lk_rd_trdy  = lk_rd_end ? !abort_mode : tgl_r;
  assign lk_rd_abort = lk_rd_end ? abort_mode : !tgl_r;
endmodule // pci_lock_target

// [tb/bridge_txn_order_lock_test.sv]
// self-checking bench for the bridge transaction core
`timescale 1ns/1ps
module bridge_txn_order_lock_test;
  import bridge_txn_pkg::*;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  logic                 rx_valid, rx_done, tx_valid, tx_grant, tx_refused, tgt_valid;
  logic                 tgt_devid_msg, tgt_done, mst_valid, mst_go, mst_refused;
  logic                 p_valid, np_valid, np_behind_p, cpl_valid, cpl_is_read, cpl_ro;
  logic                 cpl_behind_p, p_pop, np_pop, cpl_pop, dn_prior_done, lk_rd_end;
  logic                 lk_rd_trdy, lk_rd_abort, lk_rd_start, lk_err_cpl, up_hold;
  logic                 bus_lock_line_n_i, bus_lock_line_n_o, bus_lock_line_oe;
  logic                 dn_cycle_active, pm_event_input_n, msg_valid, msg_ready, abort_mode;
  tlp_kind_e            rx_kind, tx_kind;
  rx_disp_e             rx_disp;
  tgt_resp_e            tgt_resp;
  lock_state_e          lock_state;
  logic [7:0]           rx_msg_code, msg_code, slot_pwr_value;
  logic [15:0]          rx_payload;
  logic [3:0]           tgt_cmd, mst_cmd, wait_cyc;
  logic [INT_LINES-1:0] int_line_n;
  logic [1:0]           slot_pwr_scale;
  logic [31:0]          seed = 32'h5755;
  int                   failures = 0;
  int                   num_checks = 0;
  rx_disp_e             rxq[$];
  tgt_resp_e            tgq[$];
  logic [7:0]           mq[$];

  bridge_txn_order_lock bridge_txn_order_lock_i (.*);
  pci_lock_target pci_lock_target_i (.*);
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk_gen(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  // valid is left high so back-to-back requests never glitch it
  task automatic rx_send(input tlp_kind_e k, input logic [7:0] c, input rx_disp_e e);
    rx_valid = 1'b1;
    rx_kind = k;
    rx_msg_code = c;
    rx_payload = 16'(rnd());
    rxq.push_back(e);
    tick();
  endtask
  task automatic tgt_send(input logic [3:0] c, input logic d, input tgt_resp_e e);
    tgt_valid = 1'b1;
    tgt_cmd = c;
    tgt_devid_msg = d;
    tgq.push_back(e);
    tick();
  endtask
  task automatic wait_lk(input lock_state_e s);
    for (int i = 0; i < 40 && lock_state !== s; i++)
      tick();
    chk_gen(16'(lock_state), 16'(s));
  endtask
  task automatic drain_msgs();
    for (int i = 0; i < 80 && mq.size() != 0; i++)
      tick();
    chk_gen(16'(mq.size()), 16'h0000);
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (rx_done)
      chk_gen(16'(rx_disp), 16'(rxq.pop_front()));
    if (tgt_done)
      chk_gen(16'(tgt_resp), 16'(tgq.pop_front()));
    if (msg_valid && msg_ready)
      chk_gen(16'(msg_code), 16'(mq.pop_front()));
    #2;
    msg_ready = 1'(rnd());
    bus_lock_line_n_i = 1'(rnd());
    dn_cycle_active = 1'(rnd());
  end
  initial begin
    #500000;
    failures++;
    summarize();
  end
  initial begin
    tlp_kind_e  kt[11] = '{TLP_MRD, TLP_CFGRD0, TLP_CFGWR1, TLP_MSGD, TLP_MSG, TLP_MSG,
                           TLP_MSG, TLP_MSG, TLP_MSG, TLP_CPLLK, TLP_CPLD};
    logic [7:0] ct[11] = '{8'h00, 8'h00, 8'h00, 8'h7f, 8'h7f, 8'h7e, 8'h30, 8'h20, 8'h41,
                           8'h00, 8'h00};
    rx_disp_e   et[11] = '{RX_ACCEPT, RX_ACCEPT, RX_ACCEPT, RX_UR, RX_DROP, RX_UR, RX_UR,
                           RX_MALFORMED, RX_IGNORE, RX_MALFORMED, RX_ACCEPT};
    logic [6:0] v;
    logic       ec;
    logic       en;
    {rx_valid, tx_valid, tgt_valid, tgt_devid_msg, mst_valid, dn_prior_done} = '0;
    {p_valid, np_valid, np_behind_p, cpl_valid, cpl_is_read, cpl_ro, cpl_behind_p} = '0;
    {msg_ready, bus_lock_line_n_i, dn_cycle_active, abort_mode} = '0;
    rx_kind = TLP_MRD;
    tx_kind = TLP_MRD;
    {rx_msg_code, rx_payload} = '0;
    {tgt_cmd, mst_cmd, wait_cyc} = '0;
    int_line_n = '1;
    pm_event_input_n = 1'b1;
    repeat (12) @(posedge clk);
    #2;
    srst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      mst_valid = 1'b1;
      mst_cmd = 4'(i);
      tx_valid = 1'b1;
      tx_kind = tlp_kind_e'(i);
      // command inputs hold through the target access, so the check sees them settled
      tgt_send(4'(i), 1'b0, ((16'hf0cc >> i) & 16'h1) != 0 ? TGT_CLAIM : TGT_NONE);
      chk_gen(16'({mst_go, mst_refused}),
              16'({1'(16'hfcce >> i), !1'(16'hfcce >> i)}));
      chk_gen(16'({tx_grant, tx_refused}),
              16'({1'(16'h7a1d >> i), !1'(16'h7a1d >> i)}));
    end
    tgt_send(PCI_MEM_WR, 1'b1, TGT_MABORT);
    {tgt_valid, mst_valid, tx_valid} = '0;
    for (int i = 0; i < 11; i++)
      rx_send(kt[i], ct[i], et[i]);
    rx_send(TLP_MSG, MSG_SLOT_PWR, RX_CONSUME);
    rx_valid = 1'b0;
    chk_gen(16'({slot_pwr_scale, slot_pwr_value}), {6'h00, rx_payload[9:0]});
    for (int i = 0; i < 64; i++) begin
      v = 7'(rnd());
      {p_valid, np_valid, np_behind_p, cpl_valid, cpl_is_read, cpl_ro, cpl_behind_p} = v;
      #1;
      ec = v[3] && (!v[0] || !v[6] || (v[2] && v[1]));
      en = !ec && v[5] && (!v[4] || !v[6]);
      chk_gen(16'({p_pop, np_pop, cpl_pop}), 16'({!ec && !en && v[6], en, ec}));
      tick();
    end
    int_line_n[2] = 1'b0;
    mq.push_back(MSG_ASSERT_INT + 8'h02);
    repeat (6) tick();
    int_line_n[2] = 1'b1;
    mq.push_back(MSG_DEASRT_INT + 8'h02);
    pm_event_input_n = 1'b0;
    mq.push_back(MSG_PME);
    drain_msgs();
    abort_mode = 1'b1;
    wait_cyc = 4'h2;
    rx_send(TLP_MRDLK, 8'h00, RX_ACCEPT);
    rx_send(TLP_MWR, 8'h00, RX_UR);
    rx_valid = 1'b0;
    repeat (3) tick();
    chk_gen(16'(lock_state), 16'(LK_DRAIN));
    dn_prior_done = 1'b1;
    wait_lk(LK_IDLE);
    chk_gen(16'(lk_err_cpl), 16'h0001);
    abort_mode = 1'b0;
    wait_cyc = 4'h6;
    rx_send(TLP_MRDLK, 8'h00, RX_ACCEPT);
    rx_valid = 1'b0;
    wait_lk(LK_TARGET);
    rx_send(TLP_MRD, 8'h00, RX_UR);
    rx_valid = 1'b0;
    wait_lk(LK_FULL);
    rx_send(TLP_IORD, 8'h00, RX_UR);
    rx_send(TLP_MWR, 8'h00, RX_ACCEPT);
    rx_valid = 1'b0;
    tgt_send(PCI_MEM_WR, 1'b0, TGT_RETRY);
    tgt_valid = 1'b0;
    tx_valid = 1'b1;
    tx_kind = TLP_MWR;
    #1;
    chk_gen(16'(tx_grant), 16'h0000);
    tick();
    tx_kind = TLP_CPLD;
    #1;
    chk_gen(16'(tx_grant), 16'h0001);
    tx_valid = 1'b0;
    int_line_n[1] = 1'b0;
    mq.push_back(MSG_ASSERT_INT + 8'h01);
    repeat (8) tick();
    chk_gen(16'(mq.size()), 16'h0001);
    rx_send(TLP_MSG, MSG_UNLOCK, RX_CONSUME);
    rx_valid = 1'b0;
    chk_gen(16'(lock_state), 16'(LK_IDLE));
    drain_msgs();
    repeat (4) tick();
    chk_gen(16'(rxq.size() + tgq.size()), 16'h0000);
    summarize();
  end
endmodule // bridge_txn_order_lock_test
